// ---- logic/mdv_pkg.sv ----
// Shared types and constants of the multiply/divide unit
`default_nettype none
package mdv_pkg;

    // Operations offered by the integer pipeline
    typedef enum logic [3:0] {
        OP_MULTIPLY_PAIR_S = 4'h0,
        OP_MULTIPLY_PAIR_U = 4'h1,
        OP_MULTIPLY_ADD_S = 4'h2,
        OP_MULTIPLY_ADD_U = 4'h3,
        OP_MULTIPLY_SUB_S = 4'h4,
        OP_MULTIPLY_SUB_U = 4'h5,
        OP_MULTIPLY_GPR = 4'h6,
        OP_DIVIDE_S = 4'h7,
        OP_DIVIDE_U = 4'h8
    } mdv_op_t;

    // One request from the integer pipeline
    typedef struct packed {
        mdv_op_t op;
        logic [31:0] firstOperand;
        logic [31:0] secondOperand;
    } mdv_req_t;

    // Result returned for a general register
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } mdv_gpr_t;

    localparam int SLICE_W = 16;
    localparam int BOOTH_DIGITS = 9;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

    // Divide latency and skip per dividend width class 8/16/24/32 bits
    localparam logic [5:0] DIVIDE_LAT_8 = 6'h0c;
    localparam logic [5:0] DIVIDE_LAT_16 = 6'h13;
    localparam logic [5:0] DIVIDE_LAT_24 = 6'h1a;
    localparam logic [5:0] DIVIDE_LAT_32 = 6'h21;
    localparam logic [5:0] DIVIDE_SKIP_8 = 6'h17;
    localparam logic [5:0] DIVIDE_SKIP_16 = 6'h0f;
    localparam logic [5:0] DIVIDE_SKIP_24 = 6'h07;
    localparam logic [5:0] DIVIDE_SKIP_32 = 6'h00;
    localparam logic [5:0] DIVIDE_BITS = 6'h20;

endpackage
`default_nettype wire

// ---- logic/mdv_muldiv_unit.sv ----
// Multiply/divide unit running beside the integer pipeline
//
// Overview of operation
// RQ1 - Own pipeline, never stalled by integer pipeline
// RQ2 - Booth array: 32-bit operand times 16-bit slice
// RQ3 - Second operand alone decides one or two passes
// RQ4 - Short multiply each cycle, full every second
// RQ5 - Back-to-back full multiplies stall at issue
// RQ6 - Operand size detected inside the unit
// RQ7 - Divide makes one quotient bit per cycle
// RQ8 - Divide skips 23/15/7 steps on narrow dividends
// RQ9 - Any request during divide, except in its last cycle, stalls integer pipeline
// RQ10 - Result-pair multiplies: latency/rate 1/1 or 2/2
// RQ11 - Register multiply: latency/rate 2/1 or 3/2
// RQ12 - Divide latency/rate 12/11 19/18 26/25 33/32
// RQ13 - High/low pair holds results and accumulates
// RQ14 - Quotient to low, remainder to high register
`timescale 1ns/1ps
`default_nettype none
module mdv_muldiv_unit (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reqValid,
    input wire mdv_pkg::mdv_req_t req,
    output logic issueStall,
    output logic divideBusy,
    output logic [31:0] highResult,
    output logic [31:0] lowResult,
    output mdv_pkg::mdv_gpr_t gprResult
);

    // ****************************************************
    // Decoding helpers
    // ****************************************************
    function automatic logic opSigned(input mdv_pkg::mdv_op_t op);
        return op inside {mdv_pkg::OP_MULTIPLY_PAIR_S,
            mdv_pkg::OP_MULTIPLY_ADD_S, mdv_pkg::OP_MULTIPLY_SUB_S,
            mdv_pkg::OP_MULTIPLY_GPR, mdv_pkg::OP_DIVIDE_S};
    endfunction

    function automatic logic opDivide(input mdv_pkg::mdv_op_t op);
        return op inside {mdv_pkg::OP_DIVIDE_S, mdv_pkg::OP_DIVIDE_U};
    endfunction

    // Radix-4 booth pass of 33-bit signed by 17-bit signed slice
    function automatic logic [63:0] boothPass(input logic [32:0] a,
                                              input logic [16:0] b);
        logic [63:0] acc;
        logic [63:0] am;
        logic [63:0] pp;
        logic [18:0] bz;
        logic [2:0] trip;
        acc = '0;
        am = {{31{a[32]}}, a};
        bz = {b[16], b, 1'b0};
        for (int i = 0; i < mdv_pkg::BOOTH_DIGITS; i++) begin
            trip = bz[2*i+2 -: 3];
            unique case (trip)
                3'h1, 3'h2: pp = am;
                3'h3: pp = am << 1;
                3'h4: pp = -(am << 1);
                3'h5, 3'h6: pp = -am;
                default: pp = '0;
            endcase
            acc = acc + (pp << (2 * i));
        end
        return acc;
    endfunction

    // Dividend width class: 0..3 for 8/16/24/32 bits
    function automatic logic [1:0] widthClass(input logic [31:0] v,
                                              input logic sgn);
        if (sgn ? (&v[31:7] | ~|v[31:7]) : ~|v[31:8]) return 2'h0;
        if (sgn ? (&v[31:15] | ~|v[31:15]) : ~|v[31:16]) return 2'h1;
        if (sgn ? (&v[31:23] | ~|v[31:23]) : ~|v[31:24]) return 2'h2;
        return 2'h3;
    endfunction

    // ****************************************************
    // Issue and operand sizing
    // ****************************************************
    logic p2Valid;
    mdv_pkg::mdv_op_t p2Op;
    logic [32:0] p2A;
    logic [16:0] p2BHi;
    logic [63:0] p2Low;
    logic [5:0] dvCnt;
    logic fire;
    logic sgn;
    logic shortOp;
    logic [32:0] aOp;
    logic [16:0] bLow;
    logic [63:0] pass1;
    logic [63:0] pass2Full;
    logic dvFinal;

    // Size taken from the second operand value only [RQ3] [RQ6]
    always_comb begin
        sgn = opSigned(req.op);
        shortOp = sgn ? (&req.secondOperand[31:15]
                         | ~|req.secondOperand[31:15])
                      : ~|req.secondOperand[31:16];
        aOp = {sgn & req.firstOperand[31], req.firstOperand};
        bLow = {sgn & shortOp & req.secondOperand[15],
                req.secondOperand[15:0]};
        pass1 = boothPass(aOp, bLow); // [RQ2]
        pass2Full = p2Low + (boothPass(p2A, p2BHi) << mdv_pkg::SLICE_W);
    end

    // Array busy on second pass, divide busy until its last cycle
    assign dvFinal = dvCnt == 6'h01;
    assign divideBusy = dvCnt != 6'h00;
    assign issueStall = reqValid & (p2Valid | (dvCnt > 6'h01)); // [RQ5] [RQ9]
    assign fire = reqValid & ~issueStall; // [RQ4]

    // ****************************************************
    // Second pass holding register
    // ****************************************************
    logic next_p2Valid;
    mdv_pkg::mdv_op_t next_p2Op;
    logic [32:0] next_p2A;
    logic [16:0] next_p2BHi;
    logic [63:0] next_p2Low;

    // Full-width product parks here for its second pass [RQ3]
    always_comb begin
        next_p2Valid = fire & ~opDivide(req.op) & ~shortOp;
        next_p2Op = req.op;
        next_p2A = aOp;
        next_p2BHi = {sgn & req.secondOperand[31], req.secondOperand[31:16]};
        next_p2Low = pass1;
    end

    // Runs on every edge whatever the integer pipeline does [RQ1]
    always_ff @(posedge clk) begin
        if (!resetn) begin
            p2Valid <= 1'b0;
            p2Op <= mdv_pkg::OP_MULTIPLY_PAIR_S;
            p2A <= '0;
            p2BHi <= '0;
            p2Low <= '0;
        end else begin
            p2Valid <= next_p2Valid;
            p2Op <= next_p2Op;
            p2A <= next_p2A;
            p2BHi <= next_p2BHi;
            p2Low <= next_p2Low;
        end
    end

    // ****************************************************
    // Divider state machine
    // ****************************************************
    logic [5:0] dvIter;
    logic [31:0] dvRem;
    logic [31:0] dvQuo;
    logic [31:0] dvDivisor;
    logic dvNegQ;
    logic dvNegR;
    logic [5:0] next_dvCnt;
    logic [5:0] next_dvIter;
    logic [31:0] next_dvRem;
    logic [31:0] next_dvQuo;
    logic [31:0] next_dvDivisor;
    logic next_dvNegQ;
    logic next_dvNegR;
    logic [63:0] dvResult;

    // One restoring step per cycle, padded to the fixed latency
    always_comb begin
        logic [32:0] trial;
        logic [31:0] magA;
        logic [31:0] stepRem;
        logic [31:0] stepQuo;
        logic [5:0] skip;
        logic [5:0] lat;
        trial = '0;
        magA = '0;
        skip = '0;
        lat = '0;
        stepRem = dvRem;
        stepQuo = dvQuo;
        if (dvIter != 6'h00) begin // [RQ7]
            trial = {dvRem, dvQuo[31]} - {1'b0, dvDivisor};
            stepQuo = {dvQuo[30:0], ~trial[32]};
            stepRem = trial[32] ? {dvRem[30:0], dvQuo[31]} : trial[31:0];
        end
        // Quotient to low half, remainder to high half [RQ14]
        dvResult = {dvNegR ? -stepRem : stepRem, dvNegQ ? -stepQuo : stepQuo};
        next_dvCnt = (dvCnt != 6'h00) ? dvCnt - 6'h01 : 6'h00;
        next_dvIter = (dvIter != 6'h00) ? dvIter - 6'h01 : 6'h00;
        next_dvRem = stepRem;
        next_dvQuo = stepQuo;
        next_dvDivisor = dvDivisor;
        next_dvNegQ = dvNegQ;
        next_dvNegR = dvNegR;
        unique case (widthClass(req.firstOperand, sgn)) // [RQ8] [RQ12]
            2'h0: {skip, lat} = {mdv_pkg::DIVIDE_SKIP_8,
                                 mdv_pkg::DIVIDE_LAT_8};
            2'h1: {skip, lat} = {mdv_pkg::DIVIDE_SKIP_16,
                                 mdv_pkg::DIVIDE_LAT_16};
            2'h2: {skip, lat} = {mdv_pkg::DIVIDE_SKIP_24,
                                 mdv_pkg::DIVIDE_LAT_24};
            2'h3: {skip, lat} = {mdv_pkg::DIVIDE_SKIP_32,
                                 mdv_pkg::DIVIDE_LAT_32};
        endcase
        magA = (sgn & req.firstOperand[31]) ? -req.firstOperand
                                            : req.firstOperand;
        if (fire & opDivide(req.op)) begin
            next_dvCnt = lat - 6'h01;
            next_dvIter = mdv_pkg::DIVIDE_BITS - skip; // [RQ8]
            next_dvRem = '0;
            next_dvQuo = magA << skip;
            next_dvDivisor = (sgn & req.secondOperand[31]) ? -req.secondOperand
                                                           : req.secondOperand;
            next_dvNegQ = sgn & (req.firstOperand[31] ^ req.secondOperand[31]);
            next_dvNegR = sgn & req.firstOperand[31];
        end
    end

    // Divider registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dvCnt <= 6'h00;
            dvIter <= 6'h00;
            dvRem <= '0;
            dvQuo <= '0;
            dvDivisor <= '0;
            dvNegQ <= 1'b0;
            dvNegR <= 1'b0;
        end else begin
            dvCnt <= next_dvCnt;
            dvIter <= next_dvIter;
            dvRem <= next_dvRem;
            dvQuo <= next_dvQuo;
            dvDivisor <= next_dvDivisor;
            dvNegQ <= next_dvNegQ;
            dvNegR <= next_dvNegR;
        end
    end

    // ****************************************************
    // Result pair and register result
    // ****************************************************
    mdv_pkg::mdv_gpr_t gprStage;
    mdv_pkg::mdv_gpr_t next_gprStage;
    mdv_pkg::mdv_gpr_t next_gprResult;
    logic [31:0] next_highResult;
    logic [31:0] next_lowResult;

    // A multiply finishing with a divide is younger, so it is applied on top of the divide result
    always_comb begin
        logic [63:0] base;
        logic [63:0] prod;
        mdv_pkg::mdv_op_t op;
        logic done;
        base = dvFinal ? dvResult : {highResult, lowResult};
        op = p2Valid ? p2Op : req.op;
        prod = p2Valid ? pass2Full : pass1;
        done = p2Valid | (fire & shortOp & ~opDivide(req.op));
        {next_highResult, next_lowResult} = base;
        next_gprStage = '{valid: done & (op == mdv_pkg::OP_MULTIPLY_GPR),
                          data: prod[31:0]};
        next_gprResult = gprStage; // [RQ11]
        if (done) begin // [RQ10] [RQ13]
            unique case (op)
                mdv_pkg::OP_MULTIPLY_ADD_S, mdv_pkg::OP_MULTIPLY_ADD_U:
                    {next_highResult, next_lowResult} = base + prod;
                mdv_pkg::OP_MULTIPLY_SUB_S, mdv_pkg::OP_MULTIPLY_SUB_U:
                    {next_highResult, next_lowResult} = base - prod;
                mdv_pkg::OP_MULTIPLY_PAIR_S, mdv_pkg::OP_MULTIPLY_PAIR_U:
                    {next_highResult, next_lowResult} = prod;
                default: ; // Register multiply leaves the pair alone
            endcase
        end
    end

    // Result registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            highResult <= mdv_pkg::RESULT_RESET;
            lowResult <= mdv_pkg::RESULT_RESET;
            gprStage <= '0;
            gprResult <= '0;
        end else begin
            highResult <= next_highResult;
            lowResult <= next_lowResult;
            gprStage <= next_gprStage;
            gprResult <= next_gprResult;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic shortPair;
    logic fullIssue;
    logic [63:0] refProd;
    assign shortPair = fire & shortOp & (req.op == mdv_pkg::OP_MULTIPLY_PAIR_S);
    assign fullIssue = fire & ~shortOp & ~opDivide(req.op);
    // Both operands widened first so the product keeps all 64 bits
    assign refProd = {{32{req.firstOperand[31]}}, req.firstOperand}
        * {{32{req.secondOperand[31]}}, req.secondOperand};

    sequence divideNarrow;
        fire & opDivide(req.op) & (widthClass(req.firstOperand, sgn) == 2'h0);
    endsequence
    sequence divideRuns;
        divideBusy & ~dvFinal [*8] ##1 divideBusy & ~dvFinal ##1 divideBusy
            & ~dvFinal ##1 dvFinal;
    endsequence

    shortPairValue_a: assert property (shortPair |=> // [RQ10]
        {highResult, lowResult} == $past(refProd))
        else $error("short pair multiply result wrong");
    fullPairValue_a: assert property (fullIssue // [RQ3]
        && req.op == mdv_pkg::OP_MULTIPLY_PAIR_S
        |=> p2Valid ##1 {highResult, lowResult} == $past(refProd, 2))
        else $error("full pair multiply result wrong");
    backToBack_a: assert property (fullIssue // [RQ5]
        |=> p2Valid && (!reqValid || issueStall))
        else $error("issue not stalled on busy array");
    shortRate_a: assert property (reqValid && !p2Valid && !divideBusy // [RQ4]
        |-> !issueStall)
        else $error("idle unit stalled issue");
    gprShort_a: assert property (fire && shortOp // [RQ11]
        && req.op == mdv_pkg::OP_MULTIPLY_GPR
        |=> !gprResult.valid ##1 gprResult.valid)
        else $error("register multiply short latency wrong");
    gprFull_a: assert property (fullIssue // [RQ11]
        && req.op == mdv_pkg::OP_MULTIPLY_GPR
        |=> !gprResult.valid [*2] ##1 gprResult.valid)
        else $error("register multiply full latency wrong");
    divideStall_a: assert property (divideBusy && !dvFinal && reqValid // [RQ9]
        |-> issueStall)
        else $error("request during divide not stalled");
    divideLatency_a: assert property (divideNarrow |=> divideRuns) // [RQ12]
        else $error("narrow divide latency wrong");
    divideSkip_a: assert property (divideNarrow |=> dvIter == 6'h09) // [RQ8]
        else $error("narrow divide skip count wrong");

endmodule // mdv_muldiv_unit
`default_nettype wire

// ---- test/mdv_int_pipe.sv ----
// Integer pipeline model that offers requests to the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module mdv_int_pipe (
    input wire logic clk,
    input wire logic issueStall,
    output logic reqValid,
    output mdv_pkg::mdv_req_t req
);
    // Idle until the bench offers work
    initial begin
        reqValid = 1'b0;
        req = '0;
    end

    // Offer a request at the falling edge and hold it while stalled
    task automatic issue(input mdv_pkg::mdv_req_t r, output int stalls);
        stalls = 0;
        @(negedge clk);
        reqValid = 1'b1;
        req = r;
        #1;
        while (issueStall !== 1'b0) begin
            stalls++;
            @(negedge clk);
            #1;
        end
        @(posedge clk);
    endtask

    // Release; operands flip so stale values are never mistaken for live
    task automatic drop();
        reqValid = 1'b0;
        req.firstOperand = ~req.firstOperand;
        req.secondOperand = ~req.secondOperand;
    endtask
endmodule // mdv_int_pipe
`default_nettype wire

// ---- test/test_multiply_divide_unit.sv ----
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module test_multiply_divide_unit;
    typedef struct {
        mdv_pkg::mdv_req_t r;
        int lat;
    } mdv_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic issueStall;
    logic divideBusy;
    logic reqValid;
    logic [31:0] highResult;
    logic [31:0] lowResult;
    mdv_pkg::mdv_req_t req;
    mdv_pkg::mdv_gpr_t gprResult;
    int failCount = 0;
    int compares = 0;
    int stalls;
    logic [63:0] old;
    logic [63:0] exp;
    logic isDiv;
    // Rows: request beside its latency in cycles
    mdv_row_t rows [13] = '{
        '{'{mdv_pkg::OP_MULTIPLY_PAIR_S, 32'hffff_fffd, 32'h0000_7fff}, 1},
        '{'{mdv_pkg::OP_MULTIPLY_PAIR_U, 32'h1234_5678, 32'h0000_ffff}, 1},
        '{'{mdv_pkg::OP_MULTIPLY_PAIR_S, 32'h1234_5678, 32'h0000_8000}, 2},
        '{'{mdv_pkg::OP_MULTIPLY_ADD_S, 32'h0000_0100, 32'hffff_8000}, 1},
        '{'{mdv_pkg::OP_MULTIPLY_ADD_U, 32'hffff_ffff, 32'h0001_0000}, 2},
        '{'{mdv_pkg::OP_MULTIPLY_SUB_S, 32'h7fff_ffff, 32'h8000_0000}, 2},
        '{'{mdv_pkg::OP_MULTIPLY_SUB_U, 32'h0000_0003, 32'h0000_0005}, 1},
        '{'{mdv_pkg::OP_MULTIPLY_GPR, 32'h0001_0001, 32'hffff_fff0}, 2},
        '{'{mdv_pkg::OP_MULTIPLY_GPR, 32'h0001_0001, 32'h1234_0000}, 3},
        '{'{mdv_pkg::OP_DIVIDE_S, 32'hffff_ff85, 32'h0000_0007}, 12},
        '{'{mdv_pkg::OP_DIVIDE_U, 32'h0000_ff85, 32'h0000_0010}, 19},
        '{'{mdv_pkg::OP_DIVIDE_S, 32'h0000_8000, 32'h0000_0007}, 26},
        '{'{mdv_pkg::OP_DIVIDE_U, 32'h8000_0001, 32'h0000_0003}, 33}
    };

    mdv_muldiv_unit mdv_muldiv_unit_i (
        .clk(clk),
        .resetn(resetn),
        .reqValid(reqValid),
        .req(req),
        .issueStall(issueStall),
        .divideBusy(divideBusy),
        .highResult(highResult),
        .lowResult(lowResult),
        .gprResult(gprResult)
    );

    mdv_int_pipe mdv_int_pipe_i (
        .clk(clk),
        .issueStall(issueStall),
        .reqValid(reqValid),
        .req(req)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            failCount++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // Expected pair value; acc is the pair before the operation
    function automatic logic [63:0] model(mdv_pkg::mdv_req_t r,
                                          logic [63:0] acc);
        logic [63:0] ps;
        logic [63:0] pu;
        ps = $signed(r.firstOperand) * $signed(r.secondOperand);
        pu = {32'h0, r.firstOperand} * {32'h0, r.secondOperand};
        case (r.op)
            mdv_pkg::OP_MULTIPLY_PAIR_U: return pu;
            mdv_pkg::OP_MULTIPLY_ADD_S: return acc + ps;
            mdv_pkg::OP_MULTIPLY_ADD_U: return acc + pu;
            mdv_pkg::OP_MULTIPLY_SUB_S: return acc - ps;
            mdv_pkg::OP_MULTIPLY_SUB_U: return acc - pu;
            mdv_pkg::OP_DIVIDE_S: return {
                $signed(r.firstOperand) % $signed(r.secondOperand),
                $signed(r.firstOperand) / $signed(r.secondOperand)};
            mdv_pkg::OP_DIVIDE_U: return {r.firstOperand % r.secondOperand,
                                          r.firstOperand / r.secondOperand};
            default: return ps;
        endcase
    endfunction

    task automatic finalReport();
        $display("compares=%0d mismatches=%0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: 1000 cycles, far beyond the 170 or so cycles the run needs
    initial begin
        #40000;
        failCount++;
        finalReport();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        check({divideBusy, issueStall, gprResult}, 64'h0);
        check({highResult, lowResult}, 64'h0);
        // Table rows; pair must not move before its latency is up
        foreach (rows[i]) begin
            old = {highResult, lowResult};
            exp = model(rows[i].r, old);
            isDiv = rows[i].r.op inside {mdv_pkg::OP_DIVIDE_S,
                                         mdv_pkg::OP_DIVIDE_U};
            mdv_int_pipe_i.issue(rows[i].r, stalls);
            for (int k = 1; k <= rows[i].lat + 1; k++) begin
                @(negedge clk);
                if (k == 1)
                    mdv_int_pipe_i.drop();
                check(divideBusy, isDiv && k < rows[i].lat);
                if (rows[i].r.op == mdv_pkg::OP_MULTIPLY_GPR) begin
                    check(gprResult.valid, k == rows[i].lat);
                    check({highResult, lowResult}, old);
                    if (k == rows[i].lat)
                        check(gprResult.data, exp[31:0]);
                end else begin
                    check({highResult, lowResult},
                          k < rows[i].lat ? old : exp);
                end
            end
        end
        // Short multiplies back to back are never stalled
        for (int j = 1; j <= 3; j++) begin
            mdv_int_pipe_i.issue('{mdv_pkg::OP_MULTIPLY_PAIR_S, 32'(j),
                                   32'h0000_0011}, stalls);
            check(stalls, 0);
        end
        @(negedge clk);
        mdv_int_pipe_i.drop();
        check({highResult, lowResult}, 64'h33);
        // Full multiply right behind another full one waits one cycle
        mdv_int_pipe_i.issue('{mdv_pkg::OP_MULTIPLY_PAIR_U, 32'h0000_0002,
                               32'h0002_0000}, stalls);
        mdv_int_pipe_i.issue('{mdv_pkg::OP_MULTIPLY_PAIR_U, 32'h0000_0003,
                               32'h0003_0000}, stalls);
        check(stalls, 1);
        @(negedge clk);
        mdv_int_pipe_i.drop();
        @(negedge clk);
        check({highResult, lowResult}, 64'h9_0000);
        // Multiply-add behind a divide waits, then adds onto its result
        mdv_int_pipe_i.issue('{mdv_pkg::OP_DIVIDE_S, 32'hffff_ff9c,
                               32'h0000_0007}, stalls);
        mdv_int_pipe_i.issue('{mdv_pkg::OP_MULTIPLY_ADD_S, 32'h0000_0002,
                               32'h0000_0003}, stalls);
        check(stalls, 10);
        @(negedge clk);
        mdv_int_pipe_i.drop();
        check({highResult, lowResult},
              64'hffff_fffe_ffff_fff8);
        // Reset in mid-divide abandons it
        mdv_int_pipe_i.issue('{mdv_pkg::OP_DIVIDE_U, 32'h8000_0000,
                               32'h0000_0005}, stalls);
        @(negedge clk);
        mdv_int_pipe_i.drop();
        repeat (5) @(negedge clk);
        check(divideBusy, 1'b1);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        check({divideBusy, gprResult}, 64'h0);
        check({highResult, lowResult}, 64'h0);
        mdv_int_pipe_i.issue('{mdv_pkg::OP_MULTIPLY_PAIR_S, 32'h0000_0004,
                               32'h0000_0005}, stalls);
        check(stalls, 0);
        @(negedge clk);
        mdv_int_pipe_i.drop();
        check({highResult, lowResult}, 64'h14);
        finalReport();
    end
endmodule // test_multiply_divide_unit
`default_nettype wire
